// ### hw/serial_eeprom_command_port.sv
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "eeprom_port_params.svh"
// ==========================================================
module serial_eeprom_command_port
    import eeprom_port_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    // ahb-lite
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // interrupt
    output logic             irq,
    // memory pins
    output logic             mem_sel,
    output logic             mem_sclk,
    input  wire logic        serial_memory_data_pin_in,
    output logic             serial_memory_data_pin_out,
    output logic             serial_memory_data_pin_oen
);
    // ==========================================================
    // bus capture
    logic        wr_pend, next_wr_pend;
    logic [7:0]  wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic        take;

    // ==========================================================
    // register state
    logic        busy, next_busy;
    op_e         cmd_op, next_cmd_op;
    logic        tmo_flag, next_tmo_flag;
    logic [7:0]  location, next_location;
    logic [7:0]  data_byte, next_data_byte;
    logic [1:0]  status, next_status;
    logic [1:0]  mask, next_mask;
    mem_req_s    req;
    mem_rsp_s    rsp;
    logic [1:0]  events;

    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // events: bit 0 command done, bit 1 timeout
    assign events    = {rsp.timeout, rsp.done};
    assign irq       = |(status & mask);

    always_comb begin
        next_wr_pend   = take && hwrite;
        next_wr_addr   = take ? haddr[7:0] : wr_addr;
        next_hrdata    = hrdata;
        next_busy      = busy;
        next_cmd_op    = cmd_op;
        next_tmo_flag  = tmo_flag;
        next_location  = location;
        next_data_byte = data_byte;
        next_status    = status | events;
        next_mask      = mask;
        req            = '0;
        req.op         = cmd_op;
        req.addr       = location;
        req.wdata      = data_byte;
        if (take && !hwrite) begin
            case (haddr[7:0])
                `OFS_CMD:        next_hrdata = {busy, cmd_op, 18'h0, tmo_flag, rsp.loaded,
                                                location};
                `OFS_DATA:       next_hrdata = {24'h0, data_byte};
                `OFS_IRQ_STATUS: next_hrdata = {30'h0, status};
                `OFS_IRQ_MASK:   next_hrdata = {30'h0, mask};
                default:         next_hrdata = 32'h0;
            endcase
        end
        if (wr_pend) begin
            case (wr_addr)
                `OFS_CMD: begin
                    // commands while busy are dropped; software must poll first
                    if (!busy && hwdata[`CMD_BUSY_BIT]) begin
                        next_busy     = 1'b1;
                        next_cmd_op   = op_e'(hwdata[`CMD_CODE_LSB +: 3]);
                        next_tmo_flag = 1'b0;
                        next_location = hwdata[7:0];
                        req.start     = 1'b1;
                        req.op        = op_e'(hwdata[`CMD_CODE_LSB +: 3]);
                        req.addr      = hwdata[7:0];
                    end else if (!busy) begin
                        next_location = hwdata[7:0];
                    end
                end
                `OFS_DATA: if (!busy) next_data_byte = hwdata[7:0];
                `OFS_IRQ_STATUS: next_status = (status & ~hwdata[1:0]) | events;
                `OFS_IRQ_MASK:   next_mask = hwdata[1:0];
                default: ;
            endcase
        end
        if (rsp.done) begin
            next_busy = 1'b0;
            if (rsp.timeout)
                next_tmo_flag = 1'b1;
            else if (cmd_op == op_read)
                next_data_byte = rsp.rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0;
            busy      <= 1'b0;
            cmd_op    <= op_read;
            tmo_flag  <= 1'b0;
            location  <= 8'h00;
            data_byte <= 8'h00;
            status    <= 2'h0;
            mask      <= 2'h0;
        end else begin
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            hrdata    <= next_hrdata;
            busy      <= next_busy;
            cmd_op    <= next_cmd_op;
            tmo_flag  <= next_tmo_flag;
            location  <= next_location;
            data_byte <= next_data_byte;
            status    <= next_status;
            mask      <= next_mask;
        end
    end

    serial_memory_engine #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_engine (
        .hclk                       (hclk),
        .hresetn                    (hresetn),
        .req                        (req),
        .rsp                        (rsp),
        .mem_sel                    (mem_sel),
        .mem_sclk                   (mem_sclk),
        .serial_memory_data_pin_in  (serial_memory_data_pin_in),
        .serial_memory_data_pin_out (serial_memory_data_pin_out),
        .serial_memory_data_pin_oen (serial_memory_data_pin_oen)
    );

    // ==========================================================
    // checks
    a_tmo_sets_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp.timeout |=> tmo_flag && !busy) else $error("timeout bit not set");
    a_tmo_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        (tmo_flag && !req.start) |=> tmo_flag) else $error("timeout bit lost");
    a_busy_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp.done |=> !busy) else $error("busy stuck");
    a_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
        (rsp.done && !rsp.timeout && cmd_op == op_read) |=> data_byte == $past(rsp.rdata))
        else $error("read data lost");
    a_loaded_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp.loaded |=> rsp.loaded) else $error("loaded flag dropped");
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == |(status & mask)) else $error("irq mismatch");
    a_data_upper: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && haddr[7:0] == `OFS_DATA) |-> hrdata[31:8] == 24'h0)
        else $error("data upper bits nonzero");
    a_location_start: assert property (@(posedge hclk) disable iff (!hresetn)
        req.start |=> location == $past(req.addr)) else $error("location not taken");
    c_timeout: cover property (@(posedge hclk) disable iff (!hresetn) rsp.timeout);
    c_read_done: cover property (@(posedge hclk) disable iff (!hresetn)
        rsp.done && cmd_op == op_read);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
endmodule : serial_eeprom_command_port

// ### inc/eeprom_port_params.svh
`ifndef EEPROM_PORT_PARAMS_SVH
`define EEPROM_PORT_PARAMS_SVH

// ==========================================================
// register map
`define OFS_DATA        8'hb4
`define OFS_CMD         8'hb0
`define OFS_IRQ_STATUS  8'hb8
`define OFS_IRQ_MASK    8'hbc
// ==========================================================
// command register fields
`define CMD_BUSY_BIT    31
`define CMD_CODE_LSB    28
`define CMD_TIMEOUT_BIT 9
`define CMD_LOADED_BIT  8
// ==========================================================
// timing
`define CLK_HZ          25000000
`define TIMEOUT_MS      30
`define TIMEOUT_CYCLES  (`CLK_HZ / 1000 * `TIMEOUT_MS)
`define SCLK_DIV        8'h20
`endif

// ### inc/eeprom_port_pkg.sv
package eeprom_port_pkg;
    typedef enum logic [2:0] {
        op_read       = 3'b000,
        op_allow_ew   = 3'b001,
        op_block_ew   = 3'b010,
        op_write      = 3'b011,
        op_write_all  = 3'b100,
        op_erase      = 3'b101,
        op_erase_all  = 3'b110,
        op_reload     = 3'b111
    } op_e;

    typedef struct packed {
        logic       start;
        op_e        op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic       done;
        logic       timeout;
        logic       loaded;
        logic [7:0] rdata;
    } mem_rsp_s;
endpackage : eeprom_port_pkg

// ### hw/serial_memory_engine.sv
`timescale 1ns/1ns
`include "eeprom_port_params.svh"
// serial engine: shifts a 3-bit opcode, 8-bit address and data byte,
// then, for write and erase ops only, waits for the memory's ready level on the data pin
module serial_memory_engine
    import eeprom_port_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic     hclk,
    input  wire logic     hresetn,
    // request and answer
    input  wire mem_req_s req,
    output mem_rsp_s      rsp,
    // memory pins
    output logic          mem_sel,
    output logic          mem_sclk,
    input  wire logic     serial_memory_data_pin_in,
    output logic          serial_memory_data_pin_out,
    output logic          serial_memory_data_pin_oen
);
    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_shift = 3'b001,
        st_wait  = 3'b010,
        st_done  = 3'b011
    } st_e;

    st_e         state, next_state;
    op_e         op, next_op;
    logic [18:0] sh, next_sh;
    logic [4:0]  bits, next_bits;
    logic [7:0]  div, next_div;
    logic [31:0] tmo, next_tmo;
    logic        sclk, next_sclk;
    logic        timeout, next_timeout;
    logic        loaded, next_loaded;
    logic [7:0]  rdata, next_rdata;
    logic        tick;

    // ops that really program the array, and so wait on the ready level
    function automatic logic programs(op_e o);
        return o == op_write || o == op_write_all || o == op_erase || o == op_erase_all;
    endfunction : programs

    assign tick = (div == `SCLK_DIV);

    always_comb begin
        next_state   = state;
        next_op      = op;
        next_sh      = sh;
        next_bits    = bits;
        next_div     = tick ? 8'h00 : div + 8'h01;
        next_sclk    = sclk;
        next_tmo     = tmo;
        next_timeout = 1'b0;
        next_loaded  = loaded;
        next_rdata   = rdata;
        case (state)
            st_idle: begin
                if (req.start) begin
                    next_state = st_shift;
                    next_op    = req.op;
                    next_sh    = {req.op, req.addr, req.wdata};
                    next_bits  = 5'd19;
                    next_sclk  = 1'b0;
                end
            end
            st_shift: begin
                if (tick) begin
                    next_sclk = ~sclk;
                    if (sclk) begin
                        next_sh    = {sh[17:0], 1'b0};
                        next_rdata = {rdata[6:0], serial_memory_data_pin_in};
                        next_bits  = bits - 5'd1;
                        if (bits == 5'd1) begin
                            next_state = programs(op) ? st_wait : st_done;
                            next_tmo   = 32'h0;
                        end
                    end
                end
            end
            st_wait: begin
                next_tmo = tmo + 32'h1;
                if (serial_memory_data_pin_in) begin
                    next_state = st_done;
                end else if (tmo >= TIMEOUT_CYCLES - 1) begin
                    next_state   = st_idle;
                    next_timeout = 1'b1;
                end
            end
            st_done: begin
                next_state = st_idle;
                if (op == op_reload)
                    next_loaded = 1'b1;
            end
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= st_idle;
            op      <= op_read;
            sh      <= 19'h0;
            bits    <= 5'h0;
            div     <= 8'h00;
            sclk    <= 1'b0;
            tmo     <= 32'h0;
            timeout <= 1'b0;
            loaded  <= 1'b0;
            rdata   <= 8'h00;
        end else begin
            state   <= next_state;
            op      <= next_op;
            sh      <= next_sh;
            bits    <= next_bits;
            div     <= next_div;
            sclk    <= next_sclk;
            tmo     <= next_tmo;
            timeout <= next_timeout;
            loaded  <= next_loaded;
            rdata   <= next_rdata;
        end
    end

    assign rsp.done    = (state == st_done) || timeout;
    assign rsp.timeout = timeout;
    assign rsp.loaded  = loaded;
    assign rsp.rdata   = rdata;
    assign mem_sel     = (state != st_idle);
    assign mem_sclk    = sclk;
    assign serial_memory_data_pin_out = sh[18];
    // drive only while shifting a non-read op; active low enable
    assign serial_memory_data_pin_oen = !(state == st_shift && op != op_read);

    a_timeout_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        state == st_wait |-> tmo < TIMEOUT_CYCLES) else $error("wait past limit");
    a_no_tmo_nonprog: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == st_shift && !programs(op)) |=> !timeout) else $error("bad timeout");
    a_ready_ends: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == st_wait && serial_memory_data_pin_in) |=> state == st_done)
        else $error("ready ignored");
endmodule : serial_memory_engine

// ### bench/serial_memory_model.sv
`timescale 1ns/1ns
// ==========================================================
// far-side serial memory: when fitted, pulls the pin low for a while after each driven (non-read) frame
module serial_memory_model #(
    parameter int BUSY_CYCLES = 40
) (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // 0 fitted, 1 absent with pull-up, 2 absent with pull-down
    input  wire logic [1:0] mode,
    // memory pins
    input  wire logic       mem_sel,
    input  wire logic       mem_sclk,
    input  wire logic       pin_out,
    input  wire logic       pin_oen,
    output logic            pin_in
);
    logic       sclk_q;
    logic [4:0] bits;
    int         busy;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q <= 1'b0;
            bits   <= 5'h00;
            busy   <= 0;
        end else begin
            sclk_q <= mem_sclk;
            if (!mem_sel)
                bits <= 5'h00;
            else if (mem_sclk && !sclk_q && bits != 5'h13)
                bits <= bits + 5'h01;
            // only a driven frame (not a read) starts an internal program cycle
            if (mem_sel && mem_sclk && !sclk_q && bits == 5'h12 && !pin_oen)
                busy <= BUSY_CYCLES;
            else if (busy != 0)
                busy <= busy - 1;
        end
    end

    // released pin follows its pull; a fitted memory holds it low while busy
    always_comb begin
        if (!pin_oen)
            pin_in = pin_out;
        else if (mode == 2'h2)
            pin_in = 1'b0;
        else
            pin_in = !(mode == 2'h0 && busy != 0);
    end
endmodule : serial_memory_model

// ### bench/tb_serial_eeprom_command_port.sv
`timescale 1ns/1ns
// ==========================================================
module tb_serial_eeprom_command_port;
    import eeprom_port_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, mode = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, irq, mem_sel, mem_sclk, pin_in, pin_out, pin_oen;
    int          fail_count = 0, checks_done = 0, cycles = 0;

    serial_eeprom_command_port #(.TIMEOUT_CYCLES(200)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .mem_sel(mem_sel), .mem_sclk(mem_sclk), .serial_memory_data_pin_in(pin_in),
        .serial_memory_data_pin_out(pin_out), .serial_memory_data_pin_oen(pin_oen));

    serial_memory_model #(.BUSY_CYCLES(40)) mem (
        .hclk(hclk), .hresetn(hresetn), .mode(mode), .mem_sel(mem_sel),
        .mem_sclk(mem_sclk), .pin_out(pin_out), .pin_oen(pin_oen), .pin_in(pin_in));

    initial begin
        forever #20 hclk = ~hclk;
    end

    // ==========================================================
    // reporting
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // bus cycles
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : ahb

    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task rd(input logic [31:0] a, output logic [31:0] r);
        ahb(1'b0, a, 32'h0, r);
    endtask : rd

    // start a command and poll until busy drops; bounded poll
    task run_cmd(input op_e op, input logic [7:0] loc, output logic [31:0] r);
        int n;
        wr(32'hb0, {1'b1, op, 20'h00000, loc});
        n = 0;
        rd(32'hb0, r);
        while (r[31] !== 1'b0 && n < 3000) begin
            rd(32'hb0, r);
            n++;
        end
    endtask : run_cmd

    // ==========================================================
    // scenarios
    task t_reset;
        logic [31:0] r;
        rd(32'hb0, r);
        check(r, 32'h0);
        rd(32'hb4, r);
        check(r, 32'h0);
        rd(32'hc0, r);
        check(r, 32'h0);
    endtask : t_reset

    task t_regs;
        logic [31:0] r;
        wr(32'hb4, 32'hffffffff);
        rd(32'hb4, r);
        check(r, 32'h000000ff);
        wr(32'hb0, 32'h0000005a);
        rd(32'hb0, r);
        check(r & 32'h800003ff, 32'h0000005a);
    endtask : t_regs

    // every op except reload in one pin mode; only erase/write kinds may time out when pulled low
    task t_ops(input logic [1:0] m);
        logic [31:0] r;
        logic        to;
        mode <= m;
        for (int i = 0; i < 7; i++) begin
            to = (m == 2'h2) && (i >= 3);
            run_cmd(op_e'(i), 8'h3c, r);
            check(r & 32'h800002ff, {22'h0, to, 9'h03c});
            rd(32'hb8, r);
            check({31'h0, r[1]}, {31'h0, to});
            if (i == 0) begin
                rd(32'hb4, r);
                check(r, (m == 2'h2) ? 32'h00000000 : 32'h000000ff);
            end
            wr(32'hb8, 32'h00000003);
        end
    endtask : t_ops

    task t_irq_hold;
        logic [31:0] r;
        mode <= 2'h2;
        run_cmd(op_write_all, 8'h00, r);
        wr(32'hbc, 32'h00000002);
        // mask lands at the edge the write ends on; look once it settles
        @(negedge hclk);
        check({31'h0, irq}, 32'h1);
        wr(32'hbc, 32'h00000000);
        @(negedge hclk);
        check({31'h0, irq}, 32'h0);
        wr(32'hbc, 32'h00000002);
        repeat (50) @(posedge hclk);
        rd(32'hb0, r);
        check({31'h0, r[9]}, 32'h1);
        wr(32'hb8, 32'h00000002);
        @(negedge hclk);
        check({31'h0, irq}, 32'h0);
        mode <= 2'h0;
        run_cmd(op_read, 8'h00, r);
        check({31'h0, r[9]}, 32'h0);
    endtask : t_irq_hold

    task t_reload;
        logic [31:0] r;
        mode <= 2'h0;
        run_cmd(op_reload, 8'h00, r);
        check(r & 32'h80000300, 32'h00000100);
    endtask : t_reload

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_regs();
        t_ops(2'h0);
        t_ops(2'h1);
        t_ops(2'h2);
        t_irq_hold();
        t_reload();
        tally_and_finish();
    end
endmodule : tb_serial_eeprom_command_port
